//--- hdl/fmt_if.sv
// Carrier between the query sequencer and the number formatter
`timescale 1ns/1ps
interface fmt_if;
  import query_pkg::*;
  logic             start;
  logic             decimal;
  logic [VAL_W-1:0] value;
  logic             dig_valid;
  logic             dig_last;
  logic [7:0]       dig_char;
  logic             dig_ready;

  modport src (output start, decimal, value, dig_ready, input dig_valid, dig_last, dig_char);
  modport fmt (input start, decimal, value, dig_ready, output dig_valid, dig_last, dig_char);
endinterface

//--- hdl/immediate_status_query_responder.sv
// Immediate status query responder: parses command lines, answers at once
`timescale 1ns/1ps
module immediate_status_query_responder
  import query_pkg::*;
#(
  parameter bit TWO_INPUTS       = 1'b1,
  parameter bit EXPANDED_PRESENT = 1'b0
)(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [7:0]       rx_data,
  input  wire logic             rx_valid,
  output logic                  rx_ready,
  output logic [7:0]            tx_data,
  output logic                  tx_valid,
  input  wire logic             tx_ready,
  output logic [7:0]            buf_data,
  output logic                  buf_valid,
  input  wire logic [VAL_W-1:0] analog_cmd,
  input  wire logic [VAL_W-1:0] raw_in1,
  input  wire logic [VAL_W-1:0] raw_in2,
  input  wire logic [VAL_W-1:0] raw_expanded,
  input  wire logic [7:0]       reg_rd_addr,
  output logic [VAL_W-1:0]      reg_rd_data,
  output logic                  out_high_pulse,
  output logic                  out_low_pulse,
  output logic [3:0]            out_index,
  output logic                  fmt_decimal,
  output logic                  query_ignored
);

  typedef enum logic [3:0] {
    P_FIRST, P_SECOND, P_ARG, P_PASS, P_EXEC,
    R_NAME0, R_NAME1, R_EQ, R_VAL, R_LET, R_CR
  } state_t;

  state_t           state_q;
  logic [7:0]       cmd_q;
  logic [1:0]       arg_cnt_q;
  logic [7:0]       arg_q;
  logic             dec_q;
  logic [VAL_W-1:0] val_q;
  logic             start_q;
  logic [7:0]       tx_char_q;
  logic             tx_valid_q;
  logic [7:0]       buf_data_q;
  logic             buf_valid_q;
  logic             high_q;
  logic             low_q;
  logic [3:0]       index_q;
  logic             ignored_q;
  logic [VAL_W-1:0] reg_q;

  fmt_if f ();

  number_formatter u_fmt (
    .clk     (clk),
    .sys_rst (sys_rst),
    .f       (f)
  );

  // ----------------------------------------------------------------
  // Receive decode
  // ----------------------------------------------------------------
  wire       rx_take   = rx_valid && rx_ready;
  wire       is_cr     = rx_data == CH_CR;
  wire       arg_digit = (arg_q >= CH_ZERO) && (arg_q <= CH_NINE);
  wire [3:0] arg_num   = arg_q[3:0];
  wire       one_arg   = arg_cnt_q == 2'h1;
  wire       no_arg    = arg_cnt_q == 2'h0;

  wire is_analog = cmd_q == CH_A;
  wire is_format = cmd_q == CH_F;
  wire is_high   = cmd_q == CH_H;
  wire is_low    = cmd_q == CH_L;

  // ----------------------------------------------------------------
  // Analog selector decode
  // ----------------------------------------------------------------
  wire [3:0] sel    = no_arg ? SEL_COMMAND : arg_num;
  wire       sel_ok = (no_arg || (one_arg && arg_digit)) &&
                      ((sel == SEL_COMMAND) || (sel == SEL_RAW_ONE) ||
                       (TWO_INPUTS && (sel == SEL_RAW_TWO)) ||
                       (TWO_INPUTS && EXPANDED_PRESENT && (sel == SEL_RAW_EXP)));
  wire [VAL_W-1:0] sel_val = (sel == SEL_RAW_ONE) ? raw_in1 :
                             (sel == SEL_RAW_TWO) ? raw_in2 :
                             (sel == SEL_RAW_EXP) ? raw_expanded : analog_cmd;

  wire set_hex  = is_format && one_arg && (arg_q == CH_H);
  wire set_dec  = is_format && one_arg && (arg_q == CH_D);
  wire out_cmd  = (is_high || is_low) && one_arg && arg_digit;
  wire answer   = (is_analog && sel_ok) || (is_format && no_arg);
  wire act_ok   = answer || set_hex || set_dec || out_cmd;

  // ----------------------------------------------------------------
  // Response character for fixed parts
  // ----------------------------------------------------------------
  wire [7:0] resp_char = (state_q == R_NAME0) ? CH_I :
                         (state_q == R_NAME1) ? cmd_q :
                         (state_q == R_EQ)    ? CH_EQ :
                         (state_q == R_LET)   ? (dec_q ? CH_D : CH_H) : CH_CR;
  wire       tx_free   = !tx_valid_q;

  // ----------------------------------------------------------------
  // Register access by number
  // ----------------------------------------------------------------
  wire [VAL_W-1:0] reg_sel = (reg_rd_addr == REG_ANALOG_CMD) ? analog_cmd :
                             (reg_rd_addr == REG_RAW_ONE)    ? raw_in1 :
                             (reg_rd_addr == REG_RAW_TWO && TWO_INPUTS) ? raw_in2 : '0;

  // Input accepted only while parsing; stalled from P_EXEC until the closing CR of the response is loaded
  assign rx_ready = (state_q == P_FIRST) || (state_q == P_SECOND) ||
                    (state_q == P_ARG) || (state_q == P_PASS);

  assign tx_data        = tx_char_q;
  assign tx_valid       = tx_valid_q;
  assign buf_data       = buf_data_q;
  assign buf_valid      = buf_valid_q;
  assign reg_rd_data    = reg_q;
  assign out_high_pulse = high_q;
  assign out_low_pulse  = low_q;
  assign out_index      = index_q;
  assign fmt_decimal    = dec_q;
  assign query_ignored  = ignored_q;

  assign f.start     = start_q;
  assign f.decimal   = dec_q;
  assign f.value     = val_q;
  assign f.dig_ready = (state_q == R_VAL) && tx_free;

  // ----------------------------------------------------------------
  // Side registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_q <= '0;
    end else begin
      reg_q <= reg_sel;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dec_q <= FMT_RESET;
    end else if (state_q == P_EXEC) begin
      if (set_dec) begin
        dec_q <= 1'b1;
      end else if (set_hex) begin
        dec_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      high_q    <= 1'b0;
      low_q     <= 1'b0;
      index_q   <= 4'h0;
      ignored_q <= 1'b0;
    end else begin
      high_q    <= (state_q == P_EXEC) && out_cmd && is_high;
      low_q     <= (state_q == P_EXEC) && out_cmd && is_low;
      ignored_q <= (state_q == P_EXEC) && !act_ok;
      if ((state_q == P_EXEC) && out_cmd) begin
        index_q <= arg_num;
      end
    end
  end

  // Lines that are not immediate go to the buffered queue untouched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      buf_valid_q <= 1'b0;
      buf_data_q  <= 8'h00;
    end else begin
      buf_valid_q <= rx_take && ((state_q == P_PASS) ||
                     ((state_q == P_FIRST) && !is_cr && (rx_data != CH_I)));
      if (rx_take) begin
        buf_data_q <= rx_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Parser and response sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q    <= P_FIRST;
      cmd_q      <= 8'h00;
      arg_cnt_q  <= 2'h0;
      arg_q      <= 8'h00;
      val_q      <= '0;
      start_q    <= 1'b0;
      tx_char_q  <= 8'h00;
      tx_valid_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (tx_valid_q && tx_ready) begin
        tx_valid_q <= 1'b0;
      end
      case (state_q)
        P_FIRST: begin
          if (rx_take && !is_cr) begin
            state_q <= (rx_data == CH_I) ? P_SECOND : P_PASS;
          end
        end
        P_PASS: begin
          if (rx_take && is_cr) begin
            state_q <= P_FIRST;
          end
        end
        P_SECOND: begin
          if (rx_take) begin
            cmd_q     <= rx_data;
            arg_cnt_q <= 2'h0;
            arg_q     <= 8'h00;
            state_q   <= is_cr ? P_FIRST : P_ARG;
          end
        end
        P_ARG: begin
          if (rx_take) begin
            if (is_cr) begin
              state_q <= P_EXEC;
            end else if (arg_cnt_q != ARG_MANY) begin
              arg_cnt_q <= arg_cnt_q + 2'h1;
              if (no_arg) begin
                arg_q <= rx_data;
              end
            end
          end
        end
        P_EXEC: begin
          // Acted on as soon as the terminator arrives
          val_q   <= sel_val;
          state_q <= answer ? R_NAME0 : P_FIRST;
        end
        R_NAME0, R_NAME1, R_LET, R_CR: begin
          if (tx_free) begin
            tx_char_q  <= resp_char;
            tx_valid_q <= 1'b1;
            state_q    <= (state_q == R_NAME0) ? R_NAME1 :
                          (state_q == R_NAME1) ? R_EQ :
                          (state_q == R_LET)   ? R_CR : P_FIRST;
          end
        end
        R_EQ: begin
          if (tx_free) begin
            tx_char_q  <= resp_char;
            tx_valid_q <= 1'b1;
            start_q    <= is_analog;
            state_q    <= is_analog ? R_VAL : R_LET;
          end
        end
        R_VAL: begin
          if (tx_free && f.dig_valid) begin
            tx_char_q  <= f.dig_char;
            tx_valid_q <= 1'b1;
            if (f.dig_last) begin
              state_q <= R_CR;
            end
          end
        end
        default: state_q <= P_FIRST;
      endcase
    end
  end

endmodule

//--- hdl/number_formatter.sv
// Converts a value to hexadecimal or decimal characters, one at a time
`timescale 1ns/1ps
module number_formatter
  import query_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  fmt_if.fmt        f
);

  typedef enum logic [1:0] {F_IDLE, F_HEX, F_DIV, F_EMIT} fstate_t;

  fstate_t          state_q;
  logic [VAL_W-1:0] rem_q;
  logic [2:0]       idx_q;
  logic [3:0]       cnt_q;
  logic             seen_q;
  logic             dec_q;
  logic             valid_q;
  logic             last_q;
  logic [7:0]       char_q;

  // ----------------------------------------------------------------
  // Digit decode
  // ----------------------------------------------------------------
  wire [VAL_W-1:0] weight   = DEC_WEIGHT[idx_q];
  wire             fits     = rem_q >= weight;
  wire [3:0]       nib      = rem_q[VAL_W-1 -: 4];
  wire [7:0]       hex_char = (nib < 4'hA) ? {4'h3, nib} : CH_HEX_OFS + {4'h0, nib};
  wire             dec_show = (cnt_q != 4'h0) || seen_q || (idx_q == DEC_LAST_IDX);

  assign f.dig_valid = valid_q;
  assign f.dig_last  = last_q;
  assign f.dig_char  = char_q;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= F_IDLE;
      rem_q   <= '0;
      idx_q   <= 3'h0;
      cnt_q   <= 4'h0;
      seen_q  <= 1'b0;
      dec_q   <= 1'b0;
      valid_q <= 1'b0;
      last_q  <= 1'b0;
      char_q  <= 8'h00;
    end else begin
      case (state_q)
        F_IDLE: begin
          if (f.start) begin
            rem_q   <= f.value;
            dec_q   <= f.decimal;
            idx_q   <= 3'h0;
            cnt_q   <= 4'h0;
            seen_q  <= 1'b0;
            state_q <= f.decimal ? F_DIV : F_HEX;
          end
        end
        F_HEX: begin
          // Always four digits, leading zeros kept
          char_q  <= hex_char;
          last_q  <= idx_q == HEX_LAST_IDX;
          valid_q <= 1'b1;
          rem_q   <= {rem_q[VAL_W-5:0], 4'h0};
          idx_q   <= idx_q + 3'h1;
          state_q <= F_EMIT;
        end
        F_DIV: begin
          // Repeated subtraction: time depends on the value
          if (fits) begin
            rem_q <= rem_q - weight;
            cnt_q <= cnt_q + 4'h1;
          end else begin
            cnt_q <= 4'h0;
            idx_q <= idx_q + 3'h1;
            if (dec_show) begin
              // Leading zeros suppressed
              char_q  <= {4'h3, cnt_q};
              last_q  <= idx_q == DEC_LAST_IDX;
              valid_q <= 1'b1;
              seen_q  <= 1'b1;
              state_q <= F_EMIT;
            end
          end
        end
        F_EMIT: begin
          if (f.dig_ready) begin
            valid_q <= 1'b0;
            state_q <= last_q ? F_IDLE : (dec_q ? F_DIV : F_HEX);
          end
        end
        default: state_q <= F_IDLE;
      endcase
    end
  end

endmodule

//--- hdl/query_pkg.sv
// Shared constants for the immediate status query responder
package query_pkg;

  // ----------------------------------------------------------------
  // Character codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_CR      = 8'h0D;
  localparam logic [7:0] CH_EQ      = 8'h3D;
  localparam logic [7:0] CH_ZERO    = 8'h30;
  localparam logic [7:0] CH_NINE    = 8'h39;
  localparam logic [7:0] CH_HEX_OFS = 8'h37;
  localparam logic [7:0] CH_I       = 8'h49;
  localparam logic [7:0] CH_A       = 8'h41;
  localparam logic [7:0] CH_F       = 8'h46;
  localparam logic [7:0] CH_H       = 8'h48;
  localparam logic [7:0] CH_L       = 8'h4C;
  localparam logic [7:0] CH_D       = 8'h44;

  // ----------------------------------------------------------------
  // Analog selector codes and data register numbers (049, 058, 059)
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_COMMAND  = 4'h0;
  localparam logic [3:0] SEL_RAW_ONE  = 4'h1;
  localparam logic [3:0] SEL_RAW_TWO  = 4'h2;
  localparam logic [3:0] SEL_RAW_EXP  = 4'h3;
  localparam logic [7:0] REG_ANALOG_CMD = 8'h31;
  localparam logic [7:0] REG_RAW_ONE    = 8'h3A;
  localparam logic [7:0] REG_RAW_TWO    = 8'h3B;

  // ----------------------------------------------------------------
  // Formatting
  // ----------------------------------------------------------------
  localparam int         VAL_W        = 16;
  localparam logic       FMT_RESET    = 1'b0;  // 0 = hexadecimal
  localparam logic [2:0] HEX_LAST_IDX = 3'h3;
  localparam logic [2:0] DEC_LAST_IDX = 3'h4;
  localparam logic [1:0] ARG_MANY     = 2'h2;
  localparam logic [VAL_W-1:0] DEC_WEIGHT [5] = '{16'h2710, 16'h03E8, 16'h0064, 16'h000A, 16'h0001};

endpackage

//--- verification/host_link_model.sv
// Host side of the command link: sends lines, collects response bytes
`timescale 1ns/1ps
module host_link_model
  import query_pkg::*;
(
  input wire logic       clk,
  output logic     [7:0] rx_data,
  output logic           rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  output logic           tx_ready,
  input wire logic       slow
);
  logic [7:0] got_q[$];
  logic       stuck;
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
    stuck    = 1'b0;
  end

  // Slow host stalls every other cycle
  always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clk) if (tx_valid && tx_ready) got_q.push_back(tx_data);

  // Each byte held until taken, one idle cycle between lines
  task automatic send_line(input string s);
    int n;
    for (int i = 0; i <= s.len(); i++) begin
      @(negedge clk);
      rx_data  = (i == s.len()) ? CH_CR : s[i];
      rx_valid = 1'b1;
      n = 0;
      while (rx_ready !== 1'b1 && n < 500) begin
        @(negedge clk);
        n++;
      end
      if (n == 500) stuck = 1'b1;
      @(posedge clk);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask
endmodule

//--- verification/immediate_status_query_responder_test.sv
// Self-checking testbench for the immediate status query responder
`timescale 1ns/1ps
`define CHECK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module immediate_status_query_responder_test;
  import query_pkg::*;
  logic             clk, sys_rst, rx_valid, rx_ready, tx_valid, tx_ready, buf_valid, slow;
  logic             out_high_pulse, out_low_pulse, fmt_decimal, query_ignored;
  logic [7:0]       rx_data, tx_data, buf_data, reg_rd_addr;
  logic [3:0]       out_index;
  logic [VAL_W-1:0] analog_cmd, raw_in1, raw_in2, reg_rd_data;
  logic [7:0]       buf_q[$];
  int               num_errors, tests_run, ign_cnt, high_cnt, low_cnt, n, ign_single_cnt;
  logic             rx_valid_single, rx_ready_single, tx_valid_single, tx_ready_single, ign_single;
  logic [7:0]       rx_data_single, tx_data_single;
  logic [VAL_W-1:0] reg_data_single;

  immediate_status_query_responder #(.TWO_INPUTS(1'b1), .EXPANDED_PRESENT(1'b1)) u_immediate_status_query_responder (
    .clk(clk), .sys_rst(sys_rst), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .buf_data(buf_data), .buf_valid(buf_valid),
    .analog_cmd(analog_cmd), .raw_in1(raw_in1), .raw_in2(raw_in2), .raw_expanded(16'h5555),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .out_high_pulse(out_high_pulse),
    .out_low_pulse(out_low_pulse), .out_index(out_index), .fmt_decimal(fmt_decimal),
    .query_ignored(query_ignored));
  host_link_model u_host_link_model (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));
  // Single-input variant on a link of its own
  immediate_status_query_responder #(.TWO_INPUTS(1'b0), .EXPANDED_PRESENT(1'b0))
    u_immediate_status_query_responder_single (
    .clk(clk), .sys_rst(sys_rst), .rx_data(rx_data_single), .rx_valid(rx_valid_single),
    .rx_ready(rx_ready_single), .tx_data(tx_data_single), .tx_valid(tx_valid_single),
    .tx_ready(tx_ready_single), .buf_data(), .buf_valid(), .analog_cmd(analog_cmd), .raw_in1(raw_in1),
    .raw_in2(raw_in2), .raw_expanded(16'h5555), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_data_single),
    .out_high_pulse(), .out_low_pulse(), .out_index(), .fmt_decimal(), .query_ignored(ign_single));
  host_link_model u_host_link_model_single (.clk(clk), .rx_data(rx_data_single), .rx_valid(rx_valid_single),
    .rx_ready(rx_ready_single), .tx_data(tx_data_single), .tx_valid(tx_valid_single),
    .tx_ready(tx_ready_single), .slow(1'b0));

  always @(negedge clk) begin
    if (query_ignored === 1'b1) ign_cnt++;
    if (out_high_pulse === 1'b1) high_cnt++;
    if (out_low_pulse === 1'b1) low_cnt++;
    if (buf_valid === 1'b1) buf_q.push_back(buf_data);
    if (ign_single === 1'b1) ign_single_cnt++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("Counts: %0d compares, %0d errors", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic send(input string s);
    u_host_link_model.send_line(s);
    if (u_host_link_model.stuck) begin
      num_errors++;
      $display("Error at %0t: line not accepted", $time);
      final_report();
    end
  endtask

  task automatic expect_resp(input string s);
    int w;
    w = 0;
    while (u_host_link_model.got_q.size() < s.len() + 1 && w < 400) begin
      @(negedge clk);
      w++;
    end
    if (w == 400) begin
      num_errors++;
      $display("Error at %0t: response missing", $time);
      final_report();
    end
    repeat (4) @(negedge clk);
    `CHECK(u_host_link_model.got_q.size(), s.len() + 1)
    for (int i = 0; i < s.len(); i++) `CHECK(u_host_link_model.got_q[i], s[i])
    `CHECK(u_host_link_model.got_q[s.len()], CH_CR)
    u_host_link_model.got_q.delete();
  endtask

  task automatic expect_quiet();
    repeat (40) @(negedge clk);
    `CHECK(u_host_link_model.got_q.size(), 0)
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_hex_select();
    send("IF");
    expect_resp("IF=H");
    slow = 1'b1;
    send("IA");
    expect_resp("IA=001F");
    send("IA0");
    expect_resp("IA=001F");
    send("IA1");
    send("IA2");
    expect_resp("IA=ABCD\rIA=0203");
    slow = 1'b0;
    send("IA3");
    expect_resp("IA=5555");
    n = ign_cnt;
    send("IA4");
    expect_quiet();
    `CHECK(ign_cnt, n + 1)
    $display("test hex_select done");
  endtask

  task automatic t_decimal();
    send("IFD");
    expect_quiet();
    `CHECK(fmt_decimal, 1'b1)
    send("IF");
    expect_resp("IF=D");
    analog_cmd = 16'h0FA0;
    send("IA");
    expect_resp("IA=4000");
    analog_cmd = 16'h0000;
    send("IA");
    expect_resp("IA=0");
    send("IA2");
    expect_resp("IA=515");
    send("IFH");
    expect_quiet();
    `CHECK(fmt_decimal, 1'b0)
    $display("test decimal done");
  endtask

  task automatic t_outputs_and_writes();
    n = high_cnt;
    send("IH3");
    expect_quiet();
    `CHECK(high_cnt, n + 1)
    `CHECK(out_index, 4'h3)
    n = low_cnt;
    send("IL5");
    expect_quiet();
    `CHECK(low_cnt, n + 1)
    `CHECK(out_index, 4'h5)
    n = ign_cnt;
    send("IA1=5");
    expect_quiet();
    `CHECK(ign_cnt, n + 1)
    send("IA1");
    expect_resp("IA=ABCD");
    $display("test outputs_and_writes done");
  endtask

  task automatic t_buffered_regs();
    logic [VAL_W-1:0] want [3];
    logic [7:0]       addr [3];
    string            line;
    line = "HV1\r";
    buf_q.delete();
    send("HV1");
    send("IA");
    expect_resp("IA=0000");
    analog_cmd = 16'h1FEE;
    `CHECK(buf_q.size(), 4)
    for (int i = 0; i < 4; i++) `CHECK(buf_q[i], line[i])
    addr = '{REG_ANALOG_CMD, REG_RAW_ONE, REG_RAW_TWO};
    want = '{analog_cmd, raw_in1, raw_in2};
    for (int i = 0; i < 3; i++) begin
      reg_rd_addr = addr[i];
      repeat (2) @(negedge clk);
      `CHECK(reg_rd_data, want[i])
    end
    reg_rd_addr = 8'h00;
    repeat (2) @(negedge clk);
    `CHECK(reg_rd_data, 16'h0000)
    $display("test buffered_regs done");
  endtask

  task automatic t_single_input();
    string want;
    want = "IA=ABCD\rIA=001F\r";
    u_host_link_model_single.send_line("IA1");
    u_host_link_model_single.send_line("IA");
    u_host_link_model_single.send_line("IA2");
    u_host_link_model_single.send_line("IA3");
    repeat (60) @(negedge clk);
    `CHECK(u_host_link_model_single.stuck, 1'b0)
    `CHECK(u_host_link_model_single.got_q.size(), want.len())
    for (int i = 0; i < want.len(); i++) `CHECK(u_host_link_model_single.got_q[i], want[i])
    `CHECK(ign_single_cnt, 2)
    reg_rd_addr = REG_RAW_TWO;
    repeat (2) @(negedge clk);
    `CHECK(reg_data_single, 16'h0000)
    reg_rd_addr = 8'h00;
    $display("test single_input done");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    sys_rst     = 1'b1;
    slow        = 1'b0;
    reg_rd_addr = 8'h00;
    analog_cmd  = 16'h001F;
    raw_in1     = 16'hABCD;
    raw_in2     = 16'h0203;
    num_errors  = 0;
    tests_run   = 0;
    ign_cnt     = 0;
    high_cnt    = 0;
    low_cnt     = 0;
    ign_single_cnt = 0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_single_input();
    t_hex_select();
    t_decimal();
    t_outputs_and_writes();
    t_buffered_regs();
    final_report();
  end
endmodule

//--- verification/query_responder_sva.sv
// Port assertions for the immediate status query responder
`timescale 1ns/1ps
module query_responder_sva
  import query_pkg::*;
(
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic [7:0]       rx_data,
  input wire logic             rx_valid,
  input wire logic             rx_ready,
  input wire logic [7:0]       tx_data,
  input wire logic             tx_valid,
  input wire logic             tx_ready,
  input wire logic [VAL_W-1:0] analog_cmd,
  input wire logic [VAL_W-1:0] raw_in1,
  input wire logic [7:0]       reg_rd_addr,
  input wire logic [VAL_W-1:0] reg_rd_data,
  input wire logic             out_high_pulse,
  input wire logic             out_low_pulse,
  input wire logic             fmt_decimal,
  input wire logic             query_ignored
);
  // ----------------------------------------
  // Line position tracking
  // ----------------------------------------
  logic       take;
  logic [1:0] pos_q;
  logic [3:0] cr_age_q;
  logic [7:0] b0_q;
  logic [7:0] b1_q;
  assign take = rx_valid && rx_ready;

  always_ff @(posedge clk) begin
    if (sys_rst || (take && rx_data == CH_CR)) begin
      pos_q <= 2'h0;
    end else if (take && pos_q != 2'h3) begin
      pos_q <= pos_q + 2'h1;
    end
    if (sys_rst) begin
      cr_age_q <= 4'hF;
    end else if (take && rx_data == CH_CR) begin
      cr_age_q <= 4'h0;
    end else if (cr_age_q != 4'hF) begin
      cr_age_q <= cr_age_q + 4'h1;
    end
    if (take && pos_q == 2'h0) begin
      b0_q <= rx_data;
    end
    if (take && pos_q == 2'h1) begin
      b1_q <= rx_data;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !tx_valid && !fmt_decimal && !query_ignored)
    else $error("outputs active after reset");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("response byte dropped before taken");
  a_busy_stall: assert property (tx_valid && tx_data != CH_CR |-> !rx_ready)
    else $error("receive open while responding");
  a_resp_prompt: assert property (take && rx_data == CH_CR && pos_q == 2'h2 && b0_q == CH_I && b1_q == CH_A
    |-> ##[1:6] (tx_valid && tx_data == CH_I))
    else $error("analog query not answered promptly");
  a_fmt_cause: assert property ($changed(fmt_decimal) |-> cr_age_q <= 4'h3)
    else $error("format changed without a command line");
  a_pulse_single: assert property ((out_high_pulse || out_low_pulse) |=> !out_high_pulse && !out_low_pulse)
    else $error("output pulse longer than one cycle");
  a_ignore_quiet: assert property (query_ignored |-> !tx_valid ##1 !tx_valid)
    else $error("ignored line produced a response");
  a_reg_command: assert property (reg_rd_addr == REG_ANALOG_CMD |=> reg_rd_data == $past(analog_cmd))
    else $error("command register read wrong");
  a_reg_raw_one: assert property (reg_rd_addr == REG_RAW_ONE |=> reg_rd_data == $past(raw_in1))
    else $error("raw input one register read wrong");
  a_line_reopen: assert property (tx_valid && tx_ready && tx_data == CH_CR |-> ##[1:3] rx_ready)
    else $error("receive not reopened after response");
endmodule

bind immediate_status_query_responder query_responder_sva u_query_responder_sva (
  .clk(clk), .sys_rst(sys_rst), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .analog_cmd(analog_cmd),
  .raw_in1(raw_in1), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
  .out_high_pulse(out_high_pulse), .out_low_pulse(out_low_pulse), .fmt_decimal(fmt_decimal),
  .query_ignored(query_ignored));
